// ---- verilog/dcs_pkg.sv ----
// constants and carriers for the display command setup interpreter
package dcs_pkg;
  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_DISP_ON   = 8'haf;
  localparam logic [7:0] CMD_DISP_OFF  = 8'hae;
  localparam logic [7:0] CMD_SETUP     = 8'hca;
  localparam logic [7:0] CMD_TIMING    = 8'ha1;
  localparam logic [7:0] CMD_DATA      = 8'hbc;
  localparam logic [7:0] CMD_SCROLL    = 8'haa;
  localparam logic [7:0] CMD_IFACE     = 8'h31;
  localparam logic [7:0] CMD_SLEEP_IN  = 8'h95;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h94;
  localparam logic [7:0] CMD_VOSC_OFF  = 8'h97;
  localparam logic [7:0] CMD_VOSC_ON   = 8'h96;
  localparam logic [7:0] CMD_OSC_STOP  = 8'h93;
  localparam logic [7:0] CMD_OSC_RUN   = 8'h92;
  localparam logic [7:0] CMD_PART_IN   = 8'ha8;
  localparam logic [7:0] CMD_PART_OUT  = 8'ha9;

  localparam int SETUP_BYTES  = 9;
  localparam int TIMING_BYTES = 7;
  localparam int SCROLL_BYTES = 4;
  localparam int IFACE_BYTES  = 2;

  // setup byte indexes (0 based)
  localparam int IX_LP_HI  = 0;
  localparam int IX_LP_LO  = 1;
  localparam int IX_PANEL  = 2;
  localparam int IX_BOOST  = 3;
  localparam int IX_LINES  = 4;
  localparam int IX_HIZ    = 5;
  localparam int IX_BP     = 6;
  localparam int IX_FP_LO  = 7;
  localparam int IX_RSV    = 8;

  // field positions
  localparam int LP_HI_LSB   = 0;
  localparam int FP_HI_LSB   = 4;
  localparam int OSCDIV_LSB  = 0;
  localparam int AUTOCOL_BIT = 6;
  localparam int POLAR_BIT   = 7;
  localparam int BST1_LSB    = 0;
  localparam int BST2_LSB    = 4;

  // reset values
  localparam logic [9:0]  RST_LINE_PERIOD = 10'h049;
  localparam logic [7:0]  RST_LINE_COUNT  = 8'hdb;
  localparam logic [7:0]  RST_BACK_PORCH  = 8'h02;
  localparam logic [11:0] RST_FRONT_PORCH = 12'h001;
  localparam logic [7:0]  RST_HIZ         = 8'h00;
  localparam logic [1:0]  RST_OSC_DIV     = 2'h0;
  localparam logic [2:0]  RST_BOOST       = 3'h4;
  localparam logic [7:0]  RST_SRC_ON      = 8'h00;
  localparam logic [7:0]  RST_SRC_OFF     = 8'h46;
  localparam logic [7:0]  RST_GATE_SEL    = 8'h04;
  localparam logic [7:0]  RST_GATE_NSEL   = 8'h44;
  localparam logic [3:0]  RST_DRIVE_MODE  = 4'h0;
  localparam logic [7:0]  RST_COMMON_ELECTRODE_DRIVE_BOOST  = 8'h13;
  localparam logic [7:0]  RST_DRIVE_SW    = 8'h09;
  localparam logic [7:0]  RST_SCR_START   = 8'h00;
  localparam logic [7:0]  RST_SCR_END     = 8'hdb;
  localparam logic [7:0]  RST_SCR_LINES   = 8'h00;
  localparam logic [1:0]  RST_SCR_MODE    = 2'h3;
  localparam logic [1:0]  RST_IF_SEL      = 2'h0;
  localparam logic [1:0]  RST_IF_DIV      = 2'h0;
  localparam logic [7:0]  RST_DATA_COND   = 8'h00;

  localparam int CNT_W = 12;

  typedef struct packed {
    logic [9:0]  line_period;
    logic [11:0] front_porch;
    logic [2:0]  boost_first;
    logic [2:0]  boost_second;
    logic [7:0]  line_count;
    logic [7:0]  back_porch;
  } dcs_sync_t;

  typedef struct packed {
    logic [1:0] osc_divide;
    logic       auto_column_shift;
    logic       panel_polarity;
    logic [7:0] source_hiz;
  } dcs_now_t;

  typedef struct packed {
    logic [7:0] src_on;
    logic [7:0] src_off;
    logic [7:0] gate_sel;
    logic [7:0] gate_nsel;
    logic [3:0] drive_mode;
    logic [7:0] common_electrode_drive_boost;
    logic [7:0] drive_sw;
  } dcs_timing_t;

  typedef struct packed {
    logic [7:0] start_addr;
    logic [7:0] end_addr;
    logic [7:0] lines;
    logic [1:0] mode;
  } dcs_scroll_t;

  typedef struct packed {
    logic display_on;
    logic partial_on;
    logic sleeping;
    logic hs_write;
    logic supply_on;
    logic osc_run;
  } dcs_single_t;

  typedef enum logic [1:0] {
    DCS_BLANK_IDLE,
    DCS_BLANK_HOLD,
    DCS_BLANK_DISCHARGE
  } dcs_blank_t;
endpackage

// ---- verilog/dcs_core.sv ----
// command interpreter for the display setup command group
`timescale 1ns/1ps
module dcs_core
  import dcs_pkg::*;
#(
  parameter int FRAME_LINES_MIN = 1
) (
  CORE_CLK,
  RST,
  WR_STB,
  CMD_DATA_SELECT,
  DATA_IN,
  VSYNC,
  PATH_READY,
  DISPLAY_ON,
  BLANK_DRIVE,
  GATE_ALL_ON,
  DISCHARGE,
  ON_PENDING,
  SYNC_SET,
  NOW_SET,
  COLUMN_SHIFT,
  BLANK_LEVEL,
  TIMING_SET,
  SCROLL_SET,
  IF_SELECT,
  IF_DIVIDE,
  DATA_COND,
  SINGLE_STATE
);
  input  wire logic        CORE_CLK;
  input  wire logic        RST;
  input  wire logic        WR_STB;
  input  wire logic        CMD_DATA_SELECT;
  input  wire logic [7:0]  DATA_IN;
  input  wire logic        VSYNC;
  input  wire logic        PATH_READY;
  output logic             DISPLAY_ON;
  output logic             BLANK_DRIVE;
  output logic             GATE_ALL_ON;
  output logic             DISCHARGE;
  output logic             ON_PENDING;
  output dcs_sync_t        SYNC_SET;
  output dcs_now_t         NOW_SET;
  output logic [7:0]       COLUMN_SHIFT;
  output logic             BLANK_LEVEL;
  output dcs_timing_t      TIMING_SET;
  output dcs_scroll_t      SCROLL_SET;
  output logic [1:0]       IF_SELECT;
  output logic [1:0]       IF_DIVIDE;
  output logic [7:0]       DATA_COND;
  output dcs_single_t      SINGLE_STATE;

  if (FRAME_LINES_MIN < 1 || FRAME_LINES_MIN > 15) begin : g_chk
    $error("FRAME_LINES_MIN must be 1..15");
  end

  // the byte index is four bits and stops at 15
  if (SETUP_BYTES > 15 || TIMING_BYTES > 15) begin : g_chk_cnt
    $error("parameter byte counts must fit the byte index");
  end

  // the reserved byte must be the last one of the setup set
  if (IX_RSV != SETUP_BYTES - 1) begin : g_chk_ix
    $error("setup byte indexes do not match the byte count");
  end

  logic [7:0]  cur_cmd_ff;
  logic [3:0]  idx_ff;
  logic [7:0]  shadow_ff [SETUP_BYTES];
  logic        upd_pend_ff;
  dcs_sync_t   sync_ff;
  dcs_now_t    now_ff;
  dcs_timing_t tim_ff;
  dcs_scroll_t scr_ff;
  logic [1:0]  if_sel_ff;
  logic [1:0]  if_div_ff;
  logic [7:0]  dcond_ff;
  dcs_single_t single_ff;
  logic        on_pend_ff;
  logic        off_req_ff;
  dcs_blank_t  blank_ff;
  logic [3:0]  frame_cnt_ff;

  logic        cmd_wr;
  logic        par_wr;
  logic [3:0]  nxt_idx;
  logic [7:0]  col_shift;

  assign cmd_wr = WR_STB && !CMD_DATA_SELECT;
  assign par_wr = WR_STB &&  CMD_DATA_SELECT;
  assign nxt_idx = idx_ff + 4'h1;

  // command capture; a nop does not even disturb the open command
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cur_cmd_ff <= CMD_NOP;
      idx_ff     <= 4'h0;
    end else if (cmd_wr && DATA_IN != CMD_NOP) begin
      cur_cmd_ff <= DATA_IN;
      idx_ff     <= 4'h0;
    end else if (par_wr && idx_ff != 4'hf) begin
      idx_ff     <= nxt_idx;
    end
  end

  // shadow bytes, only the setup command fills them
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < SETUP_BYTES; i++) begin
        shadow_ff[i] <= 8'h00;
      end
    end else if (par_wr && cur_cmd_ff == CMD_SETUP &&
                 idx_ff < 4'(SETUP_BYTES)) begin
      shadow_ff[idx_ff] <= DATA_IN;
    end
  end

  // pending flag: set by the ninth byte, cleared on vsync; a drop on a new command
  // before completion is automatic since set only at the last byte
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      upd_pend_ff <= 1'b0;
    end else if (par_wr && cur_cmd_ff == CMD_SETUP &&
                 idx_ff == 4'(SETUP_BYTES - 1)) begin
      upd_pend_ff <= 1'b1;
    end else if (VSYNC) begin
      upd_pend_ff <= 1'b0;
    end
  end

  // vsync-synced fields; reserved byte nine is ignored by design
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sync_ff.line_period  <= RST_LINE_PERIOD;
      sync_ff.front_porch  <= RST_FRONT_PORCH;
      sync_ff.boost_first  <= RST_BOOST;
      sync_ff.boost_second <= RST_BOOST;
      sync_ff.line_count   <= RST_LINE_COUNT;
      sync_ff.back_porch   <= RST_BACK_PORCH;
    end else if (upd_pend_ff && VSYNC) begin
      sync_ff.line_period  <= {shadow_ff[IX_LP_HI][LP_HI_LSB +: 2],
                               shadow_ff[IX_LP_LO]};
      sync_ff.front_porch  <= {shadow_ff[IX_LP_HI][FP_HI_LSB +: 4],
                               shadow_ff[IX_FP_LO]};
      sync_ff.boost_first  <= shadow_ff[IX_BOOST][BST1_LSB +: 3];
      sync_ff.boost_second <= shadow_ff[IX_BOOST][BST2_LSB +: 3];
      sync_ff.line_count   <= shadow_ff[IX_LINES];
      sync_ff.back_porch   <= shadow_ff[IX_BP];
    end
  end

  // bytes three and six take effect at once
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      now_ff.osc_divide        <= RST_OSC_DIV;
      now_ff.auto_column_shift <= 1'b0;
      now_ff.panel_polarity    <= 1'b0;
      now_ff.source_hiz        <= RST_HIZ;
    end else if (par_wr && cur_cmd_ff == CMD_SETUP) begin
      if (idx_ff == 4'(IX_PANEL)) begin
        now_ff.osc_divide        <= DATA_IN[OSCDIV_LSB +: 2];
        now_ff.auto_column_shift <= DATA_IN[AUTOCOL_BIT];
        now_ff.panel_polarity    <= DATA_IN[POLAR_BIT];
      end
      if (idx_ff == 4'(IX_HIZ)) begin
        now_ff.source_hiz <= DATA_IN;
      end
    end
  end

  // display timing bytes; bytes past the seventh are ignored
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tim_ff <= '{RST_SRC_ON, RST_SRC_OFF, RST_GATE_SEL, RST_GATE_NSEL,
                  RST_DRIVE_MODE, RST_COMMON_ELECTRODE_DRIVE_BOOST, RST_DRIVE_SW};
    end else if (par_wr && cur_cmd_ff == CMD_TIMING) begin
      unique case (idx_ff)
        4'h0:    tim_ff.src_on     <= DATA_IN;
        4'h1:    tim_ff.src_off    <= DATA_IN;
        4'h2:    tim_ff.gate_sel   <= DATA_IN;
        4'h3:    tim_ff.gate_nsel  <= DATA_IN;
        4'h4:    tim_ff.drive_mode <= DATA_IN[3:0];
        4'h5:    tim_ff.common_electrode_drive_boost <= DATA_IN;
        4'h6:    tim_ff.drive_sw   <= DATA_IN;
        default: ;
      endcase
    end
  end

  // area scroll bytes
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scr_ff <= '{RST_SCR_START, RST_SCR_END, RST_SCR_LINES,
                  RST_SCR_MODE};
    end else if (par_wr && cur_cmd_ff == CMD_SCROLL) begin
      unique case (idx_ff)
        4'h0:    scr_ff.start_addr <= DATA_IN;
        4'h1:    scr_ff.end_addr   <= DATA_IN;
        4'h2:    scr_ff.lines      <= DATA_IN;
        4'h3:    scr_ff.mode       <= DATA_IN[1:0];
        default: ;
      endcase
    end
  end

  // display data interface bytes
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      if_sel_ff <= RST_IF_SEL;
      if_div_ff <= RST_IF_DIV;
    end else if (par_wr && cur_cmd_ff == CMD_IFACE) begin
      if (idx_ff == 4'h0) begin
        if_sel_ff <= DATA_IN[1:0];
      end
      if (idx_ff == 4'h1) begin
        if_div_ff <= DATA_IN[1:0];
      end
    end
  end

  // data condition byte; extra bytes are dropped
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dcond_ff <= RST_DATA_COND;
    end else if (par_wr && cur_cmd_ff == CMD_DATA && idx_ff == 4'h0) begin
      dcond_ff <= DATA_IN;
    end
  end

  // single-byte command state
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      single_ff <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    end else begin
      if (cmd_wr) begin
        unique case (DATA_IN)
          CMD_SLEEP_IN:  single_ff.sleeping   <= 1'b1;
          CMD_SLEEP_OUT: single_ff.sleeping   <= 1'b0;
          CMD_VOSC_OFF:  single_ff.supply_on  <= 1'b0;
          CMD_VOSC_ON:   single_ff.supply_on  <= 1'b1;
          CMD_OSC_STOP:  single_ff.osc_run    <= 1'b0;
          CMD_OSC_RUN:   single_ff.osc_run    <= 1'b1;
          CMD_PART_IN:   single_ff.partial_on <= 1'b1;
          CMD_PART_OUT:  single_ff.partial_on <= 1'b0;
          CMD_DISP_OFF:  single_ff.display_on <= 1'b0;
          default: ;
        endcase
      end
      // a deferred on executes once the path is up
      if (on_pend_ff && PATH_READY && !single_ff.sleeping) begin
        single_ff.display_on <= 1'b1;
      end
    end
  end

  // display-on pending flag; an off command cancels it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      on_pend_ff <= 1'b0;
    end else if (cmd_wr && DATA_IN == CMD_DISP_ON) begin
      on_pend_ff <= 1'b1;
    end else if (cmd_wr && DATA_IN == CMD_DISP_OFF) begin
      on_pend_ff <= 1'b0;
    end else if (PATH_READY && !single_ff.sleeping) begin
      on_pend_ff <= 1'b0;
    end
  end

  // off request stays until the next frame boundary
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      off_req_ff <= 1'b0;
    end else if (cmd_wr && DATA_IN == CMD_DISP_OFF) begin
      off_req_ff <= 1'b1;
    end else if (VSYNC) begin
      off_req_ff <= 1'b0;
    end
  end

  // blanking sequence: ground drive with gates on, then discharge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      blank_ff     <= DCS_BLANK_IDLE;
      frame_cnt_ff <= 4'h0;
    end else begin
      unique case (blank_ff)
        DCS_BLANK_IDLE: begin
          if (off_req_ff && VSYNC) begin
            blank_ff     <= DCS_BLANK_HOLD;
            frame_cnt_ff <= 4'h0;
          end
        end
        DCS_BLANK_HOLD: begin
          // count whole frames; the entry vsync starts the first one
          if (VSYNC) begin
            if (frame_cnt_ff == 4'(FRAME_LINES_MIN - 1)) begin
              blank_ff <= DCS_BLANK_DISCHARGE;
            end else begin
              frame_cnt_ff <= frame_cnt_ff + 4'h1;
            end
          end
        end
        DCS_BLANK_DISCHARGE: begin
          if (single_ff.display_on) begin
            blank_ff <= DCS_BLANK_IDLE;
          end
        end
      endcase
    end
  end

  // column offset follows hi-z width only when auto mode is on
  always_comb begin
    col_shift = 8'h00;
    if (now_ff.auto_column_shift && now_ff.source_hiz[3]) begin
      col_shift = {5'h00, now_ff.source_hiz[2:0]} + 8'h01;
    end
  end

  assign DISPLAY_ON   = single_ff.display_on && blank_ff == DCS_BLANK_IDLE
                        && !off_req_ff;
  assign BLANK_DRIVE  = blank_ff == DCS_BLANK_HOLD;
  assign GATE_ALL_ON  = blank_ff == DCS_BLANK_HOLD;
  assign DISCHARGE    = blank_ff == DCS_BLANK_DISCHARGE;
  assign ON_PENDING   = on_pend_ff;
  assign SYNC_SET     = sync_ff;
  assign NOW_SET      = now_ff;
  assign COLUMN_SHIFT = col_shift;
  assign BLANK_LEVEL  = now_ff.panel_polarity;
  assign TIMING_SET   = tim_ff;
  assign SCROLL_SET   = scr_ff;
  assign IF_SELECT    = if_sel_ff;
  assign IF_DIVIDE    = if_div_ff;
  assign DATA_COND    = dcond_ff;
  assign SINGLE_STATE = single_ff;
endmodule

// ---- sim/dcs_host_model.sv ----
// host processor model writing command and parameter bytes
`timescale 1ns/1ps
module dcs_host_model (
  input  wire logic       clk,
  output logic            wr_stb,
  output logic            sel,
  output logic [7:0]      data
);
  initial begin
    wr_stb = 1'b0;
    sel    = 1'b1;
    data   = 8'h00;
  end

  // one byte per strobe, changed only on the falling edge
  task automatic send(input logic s, input logic [7:0] v);
    @(negedge clk);
    wr_stb = 1'b1;
    sel    = s;
    data   = v;
    @(negedge clk);
    wr_stb = 1'b0;
    // released bus shows junk, not the last byte
    data   = ~v;
  endtask
endmodule

// ---- sim/dcs_properties.sv ----
// checker for the display command setup interpreter ports
`timescale 1ns/1ps
module dcs_properties
  import dcs_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        WR_STB,
  input wire logic        CMD_DATA_SELECT,
  input wire logic [7:0]  DATA_IN,
  input wire logic        VSYNC,
  input wire logic        PATH_READY,
  input wire logic        DISPLAY_ON,
  input wire logic        BLANK_DRIVE,
  input wire logic        GATE_ALL_ON,
  input wire logic        DISCHARGE,
  input wire logic        ON_PENDING,
  input wire dcs_sync_t   SYNC_SET,
  input wire dcs_now_t    NOW_SET,
  input wire logic [7:0]  COLUMN_SHIFT,
  input wire logic        BLANK_LEVEL,
  input wire dcs_single_t SINGLE_STATE
);
  logic       take_c;
  logic       take_p;
  logic [3:0] nb_ff;
  logic [3:0] nxt_nb;

  assign take_c = WR_STB && !CMD_DATA_SELECT;
  assign take_p = WR_STB && CMD_DATA_SELECT;

  // setup byte position; a no-op leaves an open setup open
  always_comb begin
    nxt_nb = nb_ff;
    if (take_c && DATA_IN != CMD_NOP) begin
      nxt_nb = (DATA_IN == CMD_SETUP) ? 4'h1 : 4'h0;
    end else if (take_p && nb_ff != 4'h0) begin
      nxt_nb = (nb_ff == 4'h9) ? 4'h0 : nb_ff + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      nb_ff <= 4'h0;
    end else begin
      nb_ff <= nxt_nb;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_NOP: assert property (
    take_c && DATA_IN == CMD_NOP && !VSYNC && !ON_PENDING |=>
    $stable(NOW_SET) && $stable(SYNC_SET) && $stable(SINGLE_STATE))
    else $error("no-op changed state");
  AST_OFF: assert property (
    take_c && DATA_IN == CMD_DISP_OFF |=> !DISPLAY_ON)
    else $error("display stayed on after off");
  AST_ONPEND: assert property (
    take_c && DATA_IN == CMD_DISP_ON && !DISPLAY_ON |=> ON_PENDING)
    else $error("display on not held pending");
  AST_ONREADY: assert property (
    $rose(SINGLE_STATE.display_on) |->
    $past(ON_PENDING) && $past(PATH_READY))
    else $error("display on without ready path");
  AST_BLANKLVL: assert property (
    BLANK_LEVEL == NOW_SET.panel_polarity)
    else $error("blank level not panel polarity");
  AST_GATE: assert property (
    BLANK_DRIVE == GATE_ALL_ON)
    else $error("gates not on during ground drive");
  AST_DISCH: assert property (
    $rose(DISCHARGE) |-> $past(BLANK_DRIVE))
    else $error("discharge without blank hold");
  AST_SYNC: assert property (
    !$stable(SYNC_SET) && !$past(RST) |-> $past(VSYNC))
    else $error("synced setup changed off frame sync");
  AST_PANEL: assert property (
    take_p && nb_ff == 4'h3 |=>
    NOW_SET.osc_divide == $past(DATA_IN[1:0]) &&
    NOW_SET.auto_column_shift == $past(DATA_IN[6]) &&
    NOW_SET.panel_polarity == $past(DATA_IN[7]))
    else $error("third setup byte not applied at once");
  AST_HIZ: assert property (
    take_p && nb_ff == 4'h6 |=> NOW_SET.source_hiz == $past(DATA_IN))
    else $error("sixth setup byte not applied at once");
  AST_COL: assert property (
    !NOW_SET.auto_column_shift |-> COLUMN_SHIFT == 8'h00)
    else $error("column shift without auto column");
  AST_RSTVAL: assert property (disable iff (1'b0)
    $past(RST) |-> SYNC_SET.line_period == 10'h049 &&
    SYNC_SET.line_count == 8'hdb && !DISPLAY_ON)
    else $error("wrong value after reset");
endmodule

bind dcs_core dcs_properties dcs_properties_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .WR_STB(WR_STB),
  .CMD_DATA_SELECT(CMD_DATA_SELECT), .DATA_IN(DATA_IN), .VSYNC(VSYNC),
  .PATH_READY(PATH_READY), .DISPLAY_ON(DISPLAY_ON),
  .BLANK_DRIVE(BLANK_DRIVE), .GATE_ALL_ON(GATE_ALL_ON),
  .DISCHARGE(DISCHARGE), .ON_PENDING(ON_PENDING), .SYNC_SET(SYNC_SET),
  .NOW_SET(NOW_SET), .COLUMN_SHIFT(COLUMN_SHIFT),
  .BLANK_LEVEL(BLANK_LEVEL), .SINGLE_STATE(SINGLE_STATE)
);

// ---- sim/tb_top.sv ----
// self-checking bench for the display command setup interpreter
`timescale 1ns/1ps
module tb_top;
  import dcs_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        vs;
  logic        rdy;
  logic        wr_stb;
  logic        sel;
  logic [7:0]  din;
  logic        disp_on, blank, gate, dis, on_pend, blvl;
  dcs_sync_t   sync_set;
  dcs_sync_t   e;
  dcs_now_t    now_set;
  logic [7:0]  col;
  dcs_timing_t tim;
  dcs_scroll_t scr;
  logic [1:0]  if_sel, if_div;
  logic [7:0]  dcond;
  dcs_single_t single;
  logic [7:0]  b [9];
  int          i;
  int          k;
  int          n_fail = 0;
  int          cmp_count = 0;

  dcs_host_model dcs_host_model_i (.clk(core_clk), .wr_stb(wr_stb),
    .sel(sel), .data(din));

  dcs_core dcs_core_i (.CORE_CLK(core_clk), .RST(rst), .WR_STB(wr_stb),
    .CMD_DATA_SELECT(sel), .DATA_IN(din), .VSYNC(vs), .PATH_READY(rdy),
    .DISPLAY_ON(disp_on), .BLANK_DRIVE(blank), .GATE_ALL_ON(gate),
    .DISCHARGE(dis), .ON_PENDING(on_pend), .SYNC_SET(sync_set),
    .NOW_SET(now_set), .COLUMN_SHIFT(col), .BLANK_LEVEL(blvl),
    .TIMING_SET(tim), .SCROLL_SET(scr), .IF_SELECT(if_sel),
    .IF_DIVIDE(if_div), .DATA_COND(dcond), .SINGLE_STATE(single));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic s, input logic [7:0] v);
    dcs_host_model_i.send(s, v);
  endtask

  task automatic pulse_vsync;
    @(negedge core_clk);
    vs = 1'b1;
    @(negedge core_clk);
    vs = 1'b0;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    e = {10'h049, 12'h001, 3'h4, 3'h4, 8'hdb, 8'h02};
    chk(sync_set, e);
    chk(single, 6'b001000);
    chk(disp_on, 1'b0);
  endtask

  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    vs = 1'b0;
    rdy = 1'b0;
    do_reset();
    chk(now_set, 12'h000);
    chk(tim, {8'h00, 8'h46, 8'h04, 8'h44, 4'h0, 8'h13, 8'h09});
    chk(scr, {8'h00, 8'hdb, 8'h00, 2'h3});
    chk({if_sel, if_div}, 4'h0);
    chk(dcond, 8'h00);
    // divide codes 0 to 2, every booster and polarity code, no-op inside each set
    // reserved ninth byte always written as zero
    for (i = 0; i < 8; i++) begin
      b = '{{4'(i + 1), 2'b00, 2'(i)}, 8'(8'h30 + i),
            {i[0], i[1], 4'h0, 2'(i % 3)}, {1'b0, 3'(i), 1'b0, 3'(7 - i)},
            8'(8'hdb - 2 * i), 8'(i * 9), 8'(i), 8'(8'h10 + i), 8'h00};
      wr(1'b0, CMD_SETUP);
      for (k = 0; k < 9; k++) begin
        wr(1'b1, b[k]);
        if (k == 3) wr(1'b0, CMD_NOP);
      end
      chk(sync_set, e);
      chk(now_set, {2'(i % 3), i[1], i[0], b[5]});
      chk(blvl, i[0]);
      chk(col, (i[1] && b[5][3]) ? 8'(b[5][2:0] + 1) : 8'h00);
      e = {b[0][1:0], b[1], b[0][7:4], b[7], 3'(7 - i), 3'(i), b[4], b[6]};
      pulse_vsync();
      chk(sync_set, e);
    end
    // set broken off by another command never reaches the active set
    wr(1'b0, CMD_SETUP);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h11);
    wr(1'b0, CMD_PART_OUT);
    pulse_vsync();
    chk(sync_set, e);
    wr(1'b0, CMD_SLEEP_OUT);
    pulse_vsync();
    wr(1'b0, CMD_DISP_ON);
    repeat (3) @(negedge core_clk);
    chk({on_pend, disp_on}, 2'b10);
    rdy = 1'b1;
    for (k = 0; k < 20 && disp_on !== 1'b1; k++) @(negedge core_clk);
    if (k == 20) begin
      n_fail++;
      tally_and_finish();
    end
    chk(disp_on, 1'b1);
    wr(1'b0, CMD_DISP_OFF);
    chk(disp_on, 1'b0);
    chk({blank, gate, dis}, 3'b000);
    pulse_vsync();
    chk({blank, gate, dis}, 3'b110);
    pulse_vsync();
    chk(dis, 1'b1);
    // other parameter commands land byte by byte, the extra data condition byte ignored
    wr(1'b0, CMD_TIMING);
    for (k = 0; k < 7; k++) wr(1'b1, 8'(8'h21 + k));
    wr(1'b0, CMD_SCROLL);
    for (k = 0; k < 4; k++) wr(1'b1, 8'(8'h31 + k));
    wr(1'b0, CMD_IFACE);
    wr(1'b1, 8'h01);
    wr(1'b1, 8'h02);
    wr(1'b0, CMD_DATA);
    wr(1'b1, 8'ha5);
    wr(1'b1, 8'h5a);
    chk(tim, {8'h21, 8'h22, 8'h23, 8'h24, 4'h5, 8'h26, 8'h27});
    chk(scr, {8'h31, 8'h32, 8'h33, 2'h0});
    chk({if_sel, if_div}, 4'h6);
    chk(dcond, 8'ha5);
    do_reset();
    chk(tim, {8'h00, 8'h46, 8'h04, 8'h44, 4'h0, 8'h13, 8'h09});
    chk(dcond, 8'h00);
    tally_and_finish();
  end
endmodule
